// File: design/spr_defs.svh
// Setpoint relay controller: register offsets, fields, codes, timing.
// Assumes inclusion by the design files that use its macros; no logic here.
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SPR_OFF_CTRL 8'h00
`define SPR_OFF_ACTIVE 8'h04
`define SPR_OFF_CMD 8'h08
`define SPR_OFF_SEL 8'h0C
`define SPR_OFF_VALUE 8'h10
`define SPR_OFF_DEAD 8'h14
`define SPR_OFF_MODE 8'h18
`define SPR_OFF_ONTIME 8'h1C
`define SPR_OFF_STATUS 8'h20
`define SPR_OFF_REPORT 8'h24
`define SPR_OFF_RELAYS 8'h28
`define SPR_OFF_SCAN 8'h2C
// ---------------------------------------------------------------
// Command opcodes, CMD bits [3:0]
// ---------------------------------------------------------------
`define SPR_OP_ADD 4'h1
`define SPR_OP_DEL 4'h2
`define SPR_OP_AUTO 4'h3
`define SPR_OP_DFLT 4'h4
`define SPR_OP_TEST 4'h5
`define SPR_OP_CONF 4'h6
`define SPR_OP_NEXT 4'h7
`define SPR_OP_PREV 4'h8
`define SPR_OP_TOGL 4'h9
`define SPR_OP_ESC 4'hA
// ---------------------------------------------------------------
// Fields, reset values, sizes, timing
// ---------------------------------------------------------------
`define SPR_STS_ERR 2
`define SPR_TPP_RST 8'h01
`define SPR_NSP 8
`define SPR_RLY_PER_BRD 8
`define SPR_CLK_NS 10
`define SPR_TICK_NS 1000000000
`endif

// File: design/spr_pkg.sv
// Setpoint relay controller: shared types.
// Assumes spr_defs.svh holds the register map, opcodes and sizes; the state and trigger encodings are fixed here.
package spr_pkg;
  typedef enum logic [1:0] {TS_AUTO = 2'b00, TS_WARN = 2'b01, TS_MAN = 2'b10} spr_test_e;
  typedef enum logic [1:0] {FS_HOLD = 2'b00, FS_ON = 2'b01, FS_OFF = 2'b10} spr_fs_e;
  typedef enum logic [2:0] {TR_HEAD = 3'b000, TR_FLOW = 3'b001, TR_TOTAL = 3'b010,
                            TR_TIME = 3'b011, TR_TEMP = 3'b100} spr_trig_e;
  typedef enum logic {CS_IDLE = 1'b0, CS_AUTO = 1'b1} spr_cmd_e;
endpackage : spr_pkg

// File: design/spr_free_find.sv
// Finds the lowest-numbered unassigned relay channel.
// Assumes a busy mask from the same clock domain; purely combinational.
`timescale 1ns/10ps
module spr_free_find #(
  parameter int N = 16,
  parameter int RW = 4
) (
  input wire logic [N-1:0] busy,
  output logic found,
  output logic [RW-1:0] idx
);
  // Scan downward so the lowest free index wins
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        found = 1'b1;
        idx = RW'(i);
      end
    end
  end
endmodule : spr_free_find

// File: design/spr_sp_eval.sv
// One setpoint: hysteresis compare, timed toggle, pulse, fail-safe, manual.
// Assumes upd/tick are one-cycle pulses on clk; echo_fail already persisted.
`timescale 1ns/10ps
`include "spr_defs.svh"
module spr_sp_eval import spr_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic upd,
  input wire logic tick,
  input wire logic signed [15:0] src,
  input wire logic signed [15:0] val,
  input wire logic [15:0] dead,
  input wire logic dir_hi,
  input wire logic [2:0] trig,
  input wire logic [15:0] ont,
  input wire logic echo_fail,
  input wire logic [1:0] fs,
  input wire logic man_en,
  input wire logic man_st,
  output logic state
);
  logic act_ff, act_q_ff, st_ff;
  logic [15:0] tim_ff, cnt_ff;
  logic signed [16:0] s17, lo17, hi17, v17;
  logic drv;
  assign s17 = 17'(src);
  assign v17 = 17'(val);
  assign lo17 = v17 - 17'(signed'({1'b0, dead}));
  assign hi17 = v17 + 17'(signed'({1'b0, dead}));

  // Activation latch with deadband
  always_ff @(posedge clk) begin
    if (!rstn || !en) begin
      act_ff <= 1'b0;
      tim_ff <= '0;
    end else if (trig == TR_TIME) begin
      if (tick) begin
        if (tim_ff + 16'h0001 >= val[15:0]) begin
          tim_ff <= '0;
          act_ff <= !act_ff;
        end else begin
          tim_ff <= tim_ff + 16'h0001;
        end
      end
    end else if (upd) begin
      if (!act_ff && (dir_hi ? s17 > v17 : s17 < v17)) begin
        act_ff <= 1'b1;
      end else if (act_ff && (dir_hi ? s17 <= lo17 : s17 >= hi17)) begin
        act_ff <= 1'b0;
      end
    end
  end

  // Pulse timer restarted on each activation
  always_ff @(posedge clk) begin
    if (!rstn) begin
      act_q_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      act_q_ff <= act_ff;
      if (act_ff && !act_q_ff) begin
        cnt_ff <= ont;
      end else if (tick && cnt_ff != 16'h0000) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end
  assign drv = (ont == 16'h0000) ? act_ff : (cnt_ff != 16'h0000);

  // Output priority: manual, fail-safe, automatic
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= 1'b0;
    end else if (man_en) begin
      st_ff <= man_st;
    end else if (echo_fail && fs == FS_ON) begin
      st_ff <= 1'b1;
    end else if (echo_fail && fs == FS_OFF) begin
      st_ff <= 1'b0;
    end else if (!echo_fail) begin
      st_ff <= en && drv;
    end
  end
  assign state = st_ff;

  chk_fail_on: assert property (@(posedge clk) disable iff (!rstn)
    !man_en && echo_fail && fs == FS_ON |=> st_ff) else $error("fail-safe on not applied");
  chk_fail_hold: assert property (@(posedge clk) disable iff (!rstn)
    !man_en && echo_fail && fs == FS_HOLD |=> $stable(st_ff)) else $error("fail-safe hold moved");
  chk_high_act: assert property (@(posedge clk) disable iff (!rstn)
    en && upd && trig != TR_TIME && dir_hi && !act_ff && s17 > v17 |=> act_ff)
    else $error("high setpoint not activated");
endmodule : spr_sp_eval

// File: design/spr_relay_ctrl.sv
// Setpoint relay controller top: registers, allocation, test mode, scan.
// Assumes measurements, echo_fail and tx_done come from logic on clk.
`timescale 1ns/10ps
`include "spr_defs.svh"
module spr_relay_ctrl import spr_pkg::*; #(
  parameter int NCH = 2,
  parameter int NBRD = 2,
  parameter int TICK_CYC = `SPR_TICK_NS / `SPR_CLK_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic meas_valid,
  input wire logic [((NCH > 1) ? $clog2(NCH) : 1)-1:0] meas_ch,
  input wire logic signed [15:0] meas_head,
  input wire logic signed [15:0] meas_flow,
  input wire logic signed [15:0] meas_total,
  input wire logic signed [15:0] meas_temp,
  input wire logic temp_probe,
  input wire logic echo_fail,
  input wire logic tx_done,
  output logic [((NCH > 1) ? $clog2(NCH) : 1)-1:0] scan_ch,
  output logic [NBRD*`SPR_RLY_PER_BRD-1:0] relay
);
  localparam int NSP = `SPR_NSP;
  localparam int NRLY = NBRD * `SPR_RLY_PER_BRD;
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int RW = $clog2(NRLY);
  localparam int EW = CW + 3;
  localparam int NENT = NCH * NSP;

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [31:0] rdata_ff, tdiv_ff;
  logic tick_ff, cfg_on_ff, err_ff;
  logic [7:0] tpp_ff, tx_cnt_ff;
  logic [NCH-1:0] act_ff;
  logic [EW-1:0] sel_ff;
  logic [CW-1:0] scan_ff, wch_ff, tch_ff;
  logic [NRLY-1:0] relay_ff;
  logic [NENT-1:0] asg_ff;
  logic [RW-1:0] rid_ff [NENT];
  logic signed [15:0] val_ff [NENT];
  logic [15:0] dead_ff [NENT];
  logic [15:0] ont_ff [NENT];
  logic [5:0] cfg_ff [NENT];
  spr_cmd_e cst_ff;
  spr_test_e tst_ff;
  logic [2:0] tsp_ff;
  logic [NSP-1:0] man_ff;

  logic cmd_wr, par_wr, par_rej, found;
  logic [3:0] op;
  logic [EW-1:0] ce;
  logic [RW-1:0] wrl, fidx;
  logic [NRLY-1:0] busy, rly_on;
  logic [NCH-1:0] has;
  logic [NENT-1:0] st;

  assign cmd_wr = wr && addr == `SPR_OFF_CMD;
  assign op = wdata[3:0];
  assign ce = {wdata[8 +: CW], wdata[6:4]};
  assign wrl = wdata[16 +: RW];
  assign par_wr = wr && (addr == `SPR_OFF_VALUE || addr == `SPR_OFF_DEAD ||
                         addr == `SPR_OFF_MODE || addr == `SPR_OFF_ONTIME);
  assign par_rej = par_wr && !asg_ff[sel_ff];

  // ---------------------------------------------------------------
  // Seconds tick divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tdiv_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tdiv_ff == 32'(TICK_CYC - 1)) begin
      tdiv_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tdiv_ff <= tdiv_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_on_ff <= 1'b0;
      tpp_ff <= `SPR_TPP_RST;
      act_ff <= '0;
      sel_ff <= '0;
    end else if (wr) begin
      if (addr == `SPR_OFF_CTRL) begin
        cfg_on_ff <= wdata[0];
        tpp_ff <= (wdata[15:8] == 8'h00) ? 8'h01 : wdata[15:8];
      end
      if (addr == `SPR_OFF_ACTIVE) begin
        act_ff <= wdata[NCH-1:0];
      end
      if (addr == `SPR_OFF_SEL) begin
        sel_ff <= wdata[EW-1:0];
      end
    end
  end

  // Scan sequencing by transmissions per point
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_cnt_ff <= '0;
      scan_ff <= '0;
    end else if (tx_done) begin
      if (tx_cnt_ff + 8'h01 >= tpp_ff) begin
        tx_cnt_ff <= '0;
        scan_ff <= (scan_ff == CW'(NCH - 1)) ? '0 : scan_ff + 1'b1;
      end else begin
        tx_cnt_ff <= tx_cnt_ff + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Relay ownership, free relay search
  // ---------------------------------------------------------------
  always_comb begin
    busy = '0;
    has = '0;
    rly_on = '0;
    for (int e = 0; e < NENT; e++) begin
      if (asg_ff[e]) begin
        busy[rid_ff[e]] = 1'b1;
        has[e / NSP] = 1'b1;
        rly_on[rid_ff[e]] = rly_on[rid_ff[e]] | st[e];
      end
    end
  end

  spr_free_find #(.N(NRLY), .RW(RW)) u_free (
    .busy(busy),
    .found(found),
    .idx(fidx)
  );

  // Allocation commands and auto-assign walk
  always_ff @(posedge clk) begin
    if (!rstn) begin
      asg_ff <= '0;
      cst_ff <= CS_IDLE;
      wch_ff <= '0;
      err_ff <= 1'b0;
      for (int e = 0; e < NENT; e++) begin
        rid_ff[e] <= '0;
      end
    end else begin
      if (wr && addr == `SPR_OFF_STATUS && wdata[`SPR_STS_ERR]) begin
        err_ff <= 1'b0;
      end
      if (par_rej) begin
        err_ff <= 1'b1;
      end
      case (cst_ff)
        CS_IDLE: begin
          if (cmd_wr && op == `SPR_OP_ADD) begin
            if (!asg_ff[ce] && !busy[wrl] && int'(wrl) < NRLY) begin
              asg_ff[ce] <= 1'b1;
              rid_ff[ce] <= wrl;
            end else begin
              err_ff <= 1'b1;
            end
          end else if (cmd_wr && op == `SPR_OP_DEL) begin
            asg_ff[ce] <= 1'b0;
          end else if (cmd_wr && op == `SPR_OP_AUTO) begin
            cst_ff <= CS_AUTO;
            wch_ff <= '0;
          end else if (cmd_wr && op == `SPR_OP_DFLT) begin
            asg_ff <= '0;
          end
        end
        CS_AUTO: begin
          if (act_ff[wch_ff] && !has[wch_ff] && found) begin
            asg_ff[{wch_ff, 3'b000}] <= 1'b1;
            rid_ff[{wch_ff, 3'b000}] <= fidx;
          end
          if (wch_ff == CW'(NCH - 1)) begin
            cst_ff <= CS_IDLE;
          end else begin
            wch_ff <= wch_ff + 1'b1;
          end
        end
        default: cst_ff <= CS_IDLE;
      endcase
    end
  end

  // Setpoint parameters, accepted only once allocated
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int e = 0; e < NENT; e++) begin
        val_ff[e] <= '0;
        dead_ff[e] <= '0;
        ont_ff[e] <= '0;
        cfg_ff[e] <= '0;
      end
    end else if (par_wr && asg_ff[sel_ff]) begin
      case (addr)
        `SPR_OFF_VALUE: val_ff[sel_ff] <= wdata[15:0];
        `SPR_OFF_DEAD: dead_ff[sel_ff] <= wdata[15:0];
        `SPR_OFF_MODE: cfg_ff[sel_ff] <= wdata[5:0];
        `SPR_OFF_ONTIME: ont_ff[sel_ff] <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Test mode: warn, confirm, manual toggling
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tst_ff <= TS_AUTO;
      tch_ff <= '0;
      tsp_ff <= '0;
      man_ff <= '0;
    end else if (cmd_wr) begin
      case (tst_ff)
        TS_AUTO: if (op == `SPR_OP_TEST) begin
          tst_ff <= TS_WARN;
          tch_ff <= wdata[8 +: CW];
        end
        TS_WARN: if (op == `SPR_OP_CONF) begin
          tst_ff <= TS_MAN;
          tsp_ff <= '0;
          man_ff <= st[tch_ff * NSP +: NSP];
        end else if (op == `SPR_OP_ESC) begin
          tst_ff <= TS_AUTO;
        end
        TS_MAN: begin
          if (op == `SPR_OP_NEXT) begin
            tsp_ff <= tsp_ff + 3'h1;
          end else if (op == `SPR_OP_PREV) begin
            tsp_ff <= tsp_ff - 3'h1;
          end else if (op == `SPR_OP_TOGL) begin
            man_ff[tsp_ff] <= !man_ff[tsp_ff];
          end else if (op == `SPR_OP_ESC) begin
            tst_ff <= TS_AUTO;
          end
        end
        default: tst_ff <= TS_AUTO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-setpoint evaluation
  // ---------------------------------------------------------------
  for (genvar e = 0; e < NENT; e++) begin : g_sp
    logic signed [15:0] src;
    logic en, upd, men;
    // Trigger source selection
    always_comb begin
      case (cfg_ff[e][5:3])
        TR_FLOW: src = meas_flow;
        TR_TOTAL: src = meas_total;
        TR_TEMP: src = meas_temp;
        default: src = meas_head;
      endcase
    end
    assign en = cfg_on_ff && asg_ff[e] &&
                (cfg_ff[e][5:3] != TR_TEMP || temp_probe);
    assign upd = meas_valid && meas_ch == CW'(e / NSP);
    assign men = tst_ff == TS_MAN && tch_ff == CW'(e / NSP);
    spr_sp_eval u_ev (
      .clk(clk),
      .rstn(rstn),
      .en(en),
      .upd(upd),
      .tick(tick_ff),
      .src(src),
      .val(val_ff[e]),
      .dead(dead_ff[e]),
      .dir_hi(cfg_ff[e][0]),
      .trig(cfg_ff[e][5:3]),
      .ont(ont_ff[e]),
      .echo_fail(echo_fail),
      .fs(cfg_ff[e][2:1]),
      .man_en(men),
      .man_st(man_ff[e % NSP]),
      .state(st[e])
    );
  end

  // Relay drive: nothing energised until configuration is loaded
  always_ff @(posedge clk) begin
    if (!rstn) begin
      relay_ff <= '0;
    end else begin
      relay_ff <= cfg_on_ff ? rly_on : '0;
    end
  end

  // ---------------------------------------------------------------
  // Read port, data one cycle after strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (rd) begin
      rdata_ff <= '0;
      case (addr)
        `SPR_OFF_CTRL: rdata_ff <= {16'h0000, tpp_ff, 7'h00, cfg_on_ff};
        `SPR_OFF_ACTIVE: rdata_ff <= 32'(act_ff);
        `SPR_OFF_SEL: rdata_ff <= 32'(sel_ff);
        `SPR_OFF_VALUE: rdata_ff <= {16'h0000, val_ff[sel_ff]};
        `SPR_OFF_DEAD: rdata_ff <= {16'h0000, dead_ff[sel_ff]};
        `SPR_OFF_MODE: rdata_ff <= {26'h0, cfg_ff[sel_ff]};
        `SPR_OFF_ONTIME: rdata_ff <= {16'h0000, ont_ff[sel_ff]};
        `SPR_OFF_STATUS: rdata_ff <= {16'h0000, 3'h0, cst_ff, man_ff[tsp_ff], tsp_ff,
                                      5'h00, err_ff, tst_ff == TS_MAN, tst_ff == TS_WARN};
        // Label, board slot and relay channel of selected setpoint
        `SPR_OFF_REPORT: rdata_ff <= {8'h00, 8'(rid_ff[sel_ff] % 8),
                                      8'(rid_ff[sel_ff] / 8), 4'(sel_ff[2:0]), 3'h0, asg_ff[sel_ff]};
        `SPR_OFF_RELAYS: rdata_ff <= 32'(relay_ff);
        `SPR_OFF_SCAN: rdata_ff <= {16'h0000, tx_cnt_ff, 8'(scan_ff)};
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign rdata = rdata_ff;
  assign scan_ch = scan_ff;
  assign relay = relay_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_tpp_advance: assert property (@(posedge clk) disable iff (!rstn)
    tx_done && tx_cnt_ff + 8'h01 < tpp_ff |=> $stable(scan_ff)) else $error("scan advanced early");
  chk_relays_off: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_on_ff ##1 !cfg_on_ff |-> relay_ff == '0) else $error("relay on while unconfigured");
  chk_add_busy: assert property (@(posedge clk) disable iff (!rstn)
    cst_ff == CS_IDLE && cmd_wr && op == `SPR_OP_ADD && busy[wrl] |=> err_ff) else $error("busy relay taken");
  chk_param_gate: assert property (@(posedge clk) disable iff (!rstn)
    par_rej |=> err_ff) else $error("parameter write on unassigned setpoint not flagged");
  chk_del_release: assert property (@(posedge clk) disable iff (!rstn)
    cst_ff == CS_IDLE && cmd_wr && op == `SPR_OP_DEL |=> !asg_ff[$past(ce)]) else $error("delete ignored");
  chk_default_clr: assert property (@(posedge clk) disable iff (!rstn)
    cst_ff == CS_IDLE && cmd_wr && op == `SPR_OP_DFLT |=> asg_ff == '0) else $error("default left relays");
  chk_test_confirm: assert property (@(posedge clk) disable iff (!rstn)
    tst_ff == TS_AUTO && cmd_wr && op == `SPR_OP_TEST |=> tst_ff == TS_WARN ##0 tst_ff != TS_MAN)
    else $error("test entered without warning");
  chk_test_step: assert property (@(posedge clk) disable iff (!rstn)
    tst_ff == TS_MAN && cmd_wr && op == `SPR_OP_NEXT |=> tsp_ff == $past(tsp_ff) + 3'h1)
    else $error("next did not step");
  chk_test_exit: assert property (@(posedge clk) disable iff (!rstn)
    tst_ff != TS_AUTO && cmd_wr && op == `SPR_OP_ESC |=> tst_ff == TS_AUTO) else $error("escape ignored");
  cov_auto: cover property (@(posedge clk) disable iff (!rstn) cst_ff == CS_AUTO ##1 cst_ff == CS_IDLE);
  cov_manual: cover property (@(posedge clk) disable iff (!rstn) tst_ff == TS_MAN && man_ff != '0);
  cov_relay_on: cover property (@(posedge clk) disable iff (!rstn) relay_ff != '0);
endmodule : spr_relay_ctrl

// File: bench/spr_plant_model.sv
// Far side of the relay bank: a transducer that fires transmissions and a pump on one relay.
// Assumes the same clock as the controller; all outputs are registered on clk.
`timescale 1ns/10ps
module spr_plant_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic pump,
  output logic tx_done,
  output logic [7:0] starts
);
  logic [1:0] gap_ff;
  logic pump_ff;
  // One transmission finished every fourth cycle while scanning
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      gap_ff <= 2'h0;
      tx_done <= 1'b0;
    end else begin
      gap_ff <= gap_ff + 2'h1;
      tx_done <= (gap_ff == 2'h3);
    end
  end
  // Pump counts each energise, so relay chatter shows up as extra starts
  always_ff @(posedge clk) begin
    pump_ff <= pump & rstn;
    if (!rstn) begin
      starts <= 8'h00;
    end else if (pump && !pump_ff) begin
      starts <= starts + 8'h01;
    end
  end
endmodule : spr_plant_model

// File: bench/test_setpoint_relay_control.sv
// Self-checking bench for the setpoint relay controller.
// Assumes the register map and opcodes of spr_defs.svh and a short one-second tick.
`timescale 1ns/10ps
`include "spr_defs.svh"
module test_setpoint_relay_control;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, meas_valid = 1'b0, run = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [0:0] meas_ch = 1'b0, scan_ch;
  logic signed [15:0] meas_head = 16'sh0, meas_flow = 16'sh0, meas_total = 16'sh0, meas_temp = 16'sh0;
  logic temp_probe = 1'b0, echo_fail = 1'b0, tx_done;
  logic [15:0] relay;
  logic [7:0] starts;
  int n_errors = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  spr_relay_ctrl #(.NCH(2), .NBRD(2), .TICK_CYC(20)) DUT (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas_valid(meas_valid), .meas_ch(meas_ch),
    .meas_head(meas_head), .meas_flow(meas_flow), .meas_total(meas_total), .meas_temp(meas_temp),
    .temp_probe(temp_probe), .echo_fail(echo_fail), .tx_done(tx_done), .scan_ch(scan_ch), .relay(relay));
  spr_plant_model plant (.clk(clk), .rstn(rstn), .run(run), .pump(relay[11]), .tx_done(tx_done),
    .starts(starts));
  // ---------------------------------------------------------------
  // Bus cycles and comparison
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic measure(input logic signed [15:0] v);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_head <= v;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : measure
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("relay", 32'h0, {16'h0, relay});
    chk("scan_ch", 32'h0, {31'h0, scan_ch});
    rd_reg(`SPR_OFF_CTRL, d);
    chk("tpp", 32'h1, {24'h0, d[15:8]});
    rd_reg(`SPR_OFF_REPORT, d);
    chk("assigned", 32'h0, {31'h0, d[0]});
  endtask : t_reset
  task automatic t_assign_hyst;
    wr_reg(`SPR_OFF_CTRL, 32'h0000_0101);
    wr_reg(`SPR_OFF_CMD, 32'h000B_0001);
    wr_reg(`SPR_OFF_SEL, 32'h0000_0000);
    rd_reg(`SPR_OFF_REPORT, d);
    chk("report", 32'h0003_0101, {8'h0, d[23:8], 7'h0, d[0]});
    wr_reg(`SPR_OFF_VALUE, 32'h0000_0064);
    wr_reg(`SPR_OFF_DEAD, 32'h0000_000A);
    wr_reg(`SPR_OFF_MODE, 32'h0000_0001);
    measure(16'sd100);
    chk("relay at value", 32'h0, {31'h0, relay[11]});
    measure(16'sd101);
    chk("relay above", 32'h1, {31'h0, relay[11]});
    measure(16'sd91);
    chk("relay in band", 32'h1, {31'h0, relay[11]});
    measure(16'sd90);
    chk("relay released", 32'h0, {31'h0, relay[11]});
    chk("others", 32'h0, {16'h0, relay & 16'hF7FF});
    chk("pump starts", 32'h1, {24'h0, starts});
  endtask : t_assign_hyst
  task automatic t_test_mode;
    wr_reg(`SPR_OFF_CMD, 32'h0000_0005);
    rd_reg(`SPR_OFF_STATUS, d);
    chk("warn", 32'h1, {30'h0, d[1:0]});
    wr_reg(`SPR_OFF_CMD, 32'h0000_0006);
    wr_reg(`SPR_OFF_CMD, 32'h0000_0009);
    repeat (4) @(posedge clk);
    chk("manual on", 32'h1, {31'h0, relay[11]});
    rd_reg(`SPR_OFF_STATUS, d);
    chk("manual", 32'h3, {30'h0, d[11], d[1]});
    wr_reg(`SPR_OFF_CMD, 32'h0000_0007);
    rd_reg(`SPR_OFF_STATUS, d);
    chk("next sel", 32'h1, {28'h0, d[11:8]});
    wr_reg(`SPR_OFF_CMD, 32'h0000_0008);
    rd_reg(`SPR_OFF_STATUS, d);
    chk("prev sel", 32'h8, {28'h0, d[11:8]});
    wr_reg(`SPR_OFF_CMD, 32'h0000_000A);
    repeat (4) @(posedge clk);
    chk("auto back", 32'h0, {31'h0, relay[11]});
  endtask : t_test_mode
  task automatic t_delete;
    wr_reg(`SPR_OFF_CMD, 32'h0000_0002);
    rd_reg(`SPR_OFF_REPORT, d);
    chk("deleted", 32'h0, {31'h0, d[0]});
    wr_reg(`SPR_OFF_CMD, 32'h000B_0011);
    rd_reg(`SPR_OFF_STATUS, d);
    chk("reuse err", 32'h0, {31'h0, d[`SPR_STS_ERR]});
    wr_reg(`SPR_OFF_SEL, 32'h0000_0002);
    wr_reg(`SPR_OFF_VALUE, 32'h0000_0010);
    rd_reg(`SPR_OFF_STATUS, d);
    chk("unassigned err", 32'h1, {31'h0, d[`SPR_STS_ERR]});
  endtask : t_delete
  // Echo loss forces the energise state, then automatic control returns
  task automatic t_failsafe;
    wr_reg(`SPR_OFF_SEL, 32'h0000_0001);
    wr_reg(`SPR_OFF_MODE, 32'h0000_0002);
    echo_fail <= 1'b1;
    repeat (4) @(posedge clk);
    chk("fail-safe on", 32'h1, {31'h0, relay[11]});
    echo_fail <= 1'b0;
    repeat (4) @(posedge clk);
    chk("fail-safe end", 32'h0, {31'h0, relay[11]});
  endtask : t_failsafe
  // Default clears, auto-assign gives each active channel the lowest free relay
  task automatic t_auto;
    wr_reg(`SPR_OFF_CMD, 32'h0000_0004);
    wr_reg(`SPR_OFF_CMD, 32'h0000_0003);
    wr_reg(`SPR_OFF_SEL, 32'h0000_0008);
    rd_reg(`SPR_OFF_REPORT, d);
    chk("auto ch1", 32'h0001_0001, d);
    wr_reg(`SPR_OFF_SEL, 32'h0000_0000);
    rd_reg(`SPR_OFF_REPORT, d);
    chk("auto ch0", 32'h0000_0001, d);
    wr_reg(`SPR_OFF_ONTIME, 32'h0000_0002);
    measure(16'sd101);
    chk("pulse on", 32'h1, {31'h0, relay[0]});
    repeat (50) @(posedge clk);
    chk("pulse over", 32'h0, {31'h0, relay[0]});
  endtask : t_auto
  task automatic t_scan;
    wr_reg(`SPR_OFF_ACTIVE, 32'h0000_0003);
    wr_reg(`SPR_OFF_CTRL, 32'h0000_0301);
    run <= 1'b1;
    n = 0;
    for (int i = 0; i < 100 && scan_ch === 1'b0; i++) begin
      @(posedge clk);
      #1;
      if (scan_ch === 1'b0 && tx_done === 1'b1) n++;
    end
    @(posedge clk);
    run <= 1'b0;
    chk("tx per point", 32'h3, n);
    chk("scan advanced", 32'h1, {31'h0, scan_ch});
  endtask : t_scan
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_assign_hyst();
    t_test_mode();
    t_delete();
    t_failsafe();
    t_scan();
    t_auto();
    conclude();
  end
endmodule : test_setpoint_relay_control
